// ---- verilog/qamc_regs.sv ----
// Purpose: Mode control register bank of a quad converter.
// Assumes: Serial host on its own clock; system clock at 100 MHz.
// Notes: Registers reset to zero on reset and on software reset.
`timescale 1ns/100ps
`include "qamc_defs.svh"
// Summary of operation
// - All-zero sleep/nap field means normal operation.
// - Each set nap bit (3-0) naps its own channel.
// - Sleep bit disables all channels, nap ignored.
// - Bits 7-5 choose driver current; 011 unused.
// - Bit 4 turns internal termination on.
// - Codes 000/001/010: two lanes, 16/14/12 frames.
// - Codes 101-111 select single lane; 101 14-bit.
// - High register bit 7 enables test pattern.
// - Pattern bits come from high and low registers.
// - Low register bits 1-0 give extra bits.
// - High register bit 6 is ignored.
// - Word is flag, address, data; read leaves register.
// - Software reset clears all mode registers.
module qamc_regs
   import qamc_pkg::*;
(
   // System clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // Serial link
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // Decoded control towards the converter logic
   output qamc_ctrl_t ctrl_out,
   output logic [3:0] chan_active_out,
   output logic cur_code_bad_out,
   output logic mode_code_bad_out
);
   logic [7:0] fmt_pwr, next_fmt_pwr;
   logic [7:0] out_mode, next_out_mode;
   logic [7:0] tp_high, next_tp_high;
   logic [7:0] tp_low, next_tp_low;
   logic [7:0] rd_data, next_rd_data;
   logic [2:0] tgl_sync, next_tgl_sync;
   qamc_ctrl_t ctrl, next_ctrl;
   logic [3:0] chan_act, next_chan_act;
   logic cur_bad, next_cur_bad;
   logic mode_bad, next_mode_bad;
   qamc_wr_t word;
   logic word_tgl;
   logic port_oe;

   ////////////////////////////////////////////////////////////////////////
   qamc_serial_port u_port (
      .sclk_in(sclk_in),
      .cs_n_in(cs_n_in),
      .sdi_in(sdi_in),
      .sdo_oe_out(port_oe),
      .rd_data_in(rd_data),
      .word_out(word),
      .word_tgl_out(word_tgl)
   );

   // The open-drain output only ever pulls low.
   assign sdo_out = 1'b0;
   assign sdo_oe_out = port_oe;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] read_reg(input logic [6:0] a,
      input logic [7:0] f, input logic [7:0] o, input logic [7:0] h,
      input logic [7:0] l);
      logic [7:0] r;
      r = 8'h00;
      if (a == `QAMC_ADDR_FMT_PWR) begin
         r = f;
      end else if (a == `QAMC_ADDR_OUT_MODE) begin
         r = o;
      end else if (a == `QAMC_ADDR_TP_HIGH) begin
         r = h;
      end else if (a == `QAMC_ADDR_TP_LOW) begin
         r = l;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // The word is stable for many system cycles after its toggle, since it
   // only changes on the next frame's first serial edge; so it is read unsynchronised.
   always_comb begin
      next_tgl_sync = {tgl_sync[1:0], word_tgl};
      next_fmt_pwr = fmt_pwr;
      next_out_mode = out_mode;
      next_tp_high = tp_high;
      next_tp_low = tp_low;
      next_rd_data = rd_data;
      if (tgl_sync[1] && !tgl_sync[2]) begin
         if (!word.addr[7]) begin
            if (word.addr[6:0] == `QAMC_ADDR_RESET) begin
               if (word.data[`QAMC_RESET_BIT]) begin
                  next_fmt_pwr = `QAMC_REG_RESET_VAL;
                  next_out_mode = `QAMC_REG_RESET_VAL;
                  next_tp_high = `QAMC_REG_RESET_VAL;
                  next_tp_low = `QAMC_REG_RESET_VAL;
               end
            end else if (word.addr[6:0] == `QAMC_ADDR_FMT_PWR) begin
               next_fmt_pwr = word.data;
            end else if (word.addr[6:0] == `QAMC_ADDR_OUT_MODE) begin
               next_out_mode = word.data;
            end else if (word.addr[6:0] == `QAMC_ADDR_TP_HIGH) begin
               next_tp_high = word.data;
            end else if (word.addr[6:0] == `QAMC_ADDR_TP_LOW) begin
               next_tp_low = word.data;
            end
         end
      end
      // Readback source; limitation: the host should leave a few system
      // cycles after the address bits before the data phase begins.
      next_rd_data = read_reg(word.addr[6:0], next_fmt_pwr, next_out_mode,
         next_tp_high, next_tp_low);
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         tgl_sync <= 3'h0;
         fmt_pwr <= `QAMC_REG_RESET_VAL;
         out_mode <= `QAMC_REG_RESET_VAL;
         tp_high <= `QAMC_REG_RESET_VAL;
         tp_low <= `QAMC_REG_RESET_VAL;
         rd_data <= `QAMC_REG_RESET_VAL;
      end else if (clk_en_in) begin
         tgl_sync <= next_tgl_sync;
         fmt_pwr <= next_fmt_pwr;
         out_mode <= next_out_mode;
         tp_high <= next_tp_high;
         tp_low <= next_tp_low;
         rd_data <= next_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_ctrl = '0;
      next_ctrl.sleep = fmt_pwr[`QAMC_SLEEP_BIT];
      next_ctrl.nap = fmt_pwr[`QAMC_NAP_MSB:0];
      // Sleep overrides every nap bit; all zero leaves every channel on.
      next_chan_act = fmt_pwr[`QAMC_SLEEP_BIT] ? 4'h0 :
         ~fmt_pwr[`QAMC_NAP_MSB:0];
      next_ctrl.driver_current_sel =
         out_mode[`QAMC_CUR_MSB:`QAMC_CUR_LSB];
      next_cur_bad = out_mode[`QAMC_CUR_MSB:`QAMC_CUR_LSB] ==
         `QAMC_CUR_UNUSED;
      next_ctrl.internal_term_en = out_mode[`QAMC_TERM_BIT];
      next_ctrl.outputs_disable = out_mode[`QAMC_OFF_BIT];
      next_ctrl.two_lane = 1'b0;
      next_ctrl.frame_bits = `QAMC_FRAME_16;
      next_mode_bad = 1'b0;
      case (out_mode[`QAMC_MODE_MSB:0])
         `QAMC_MODE_2L16: begin
            next_ctrl.two_lane = 1'b1;
         end
         `QAMC_MODE_2L14: begin
            next_ctrl.two_lane = 1'b1;
            next_ctrl.frame_bits = `QAMC_FRAME_14;
         end
         `QAMC_MODE_2L12: begin
            next_ctrl.two_lane = 1'b1;
            next_ctrl.frame_bits = `QAMC_FRAME_12;
         end
         `QAMC_MODE_1L14: begin
            next_ctrl.frame_bits = `QAMC_FRAME_14;
         end
         3'h6, 3'h7: begin
            next_ctrl.two_lane = 1'b0;
         end
         default: begin
            // Reserved codes fall back to single lane and are flagged.
            next_mode_bad = 1'b1;
         end
      endcase
      next_ctrl.pattern_enable = tp_high[`QAMC_PAT_EN_BIT];
      // Bit 6 of the high register is never looked at.
      next_ctrl.pattern_data = {tp_high[`QAMC_PAT_HI_MSB:0],
         tp_low[`QAMC_PAT_LO_MSB:`QAMC_PAT_LO_LSB]};
      next_ctrl.pattern_extra_hi = tp_low[1];
      next_ctrl.pattern_extra_lo = tp_low[0];
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl <= '0;
         chan_act <= 4'h0;
         cur_bad <= 1'b0;
         mode_bad <= 1'b0;
      end else if (clk_en_in) begin
         ctrl <= next_ctrl;
         chan_act <= next_chan_act;
         cur_bad <= next_cur_bad;
         mode_bad <= next_mode_bad;
      end
   end

   assign ctrl_out = ctrl;
   assign chan_active_out = chan_act;
   assign cur_code_bad_out = cur_bad;
   assign mode_code_bad_out = mode_bad;
endmodule

// ---- verilog/qamc_defs.svh ----
// Purpose: Register offsets, field positions and decode constants.
// Assumes: Included by the design modules; the package does not include it.
// Notes: Definitions only.
`ifndef QAMC_DEFS_SVH
`define QAMC_DEFS_SVH
`define QAMC_ADDR_RESET 7'h00
`define QAMC_ADDR_FMT_PWR 7'h01
`define QAMC_ADDR_OUT_MODE 7'h02
`define QAMC_ADDR_TP_HIGH 7'h03
`define QAMC_ADDR_TP_LOW 7'h04
`define QAMC_REG_RESET_VAL 8'h00
`define QAMC_RESET_BIT 7
`define QAMC_SLEEP_BIT 4
`define QAMC_NAP_MSB 3
`define QAMC_CUR_MSB 7
`define QAMC_CUR_LSB 5
`define QAMC_TERM_BIT 4
`define QAMC_OFF_BIT 3
`define QAMC_MODE_MSB 2
`define QAMC_PAT_EN_BIT 7
`define QAMC_PAT_HI_MSB 5
`define QAMC_PAT_LO_MSB 7
`define QAMC_PAT_LO_LSB 2
`define QAMC_WORD_BITS 16
`define QAMC_CNT_W 5
`define QAMC_CUR_UNUSED 3'h3
`define QAMC_MODE_2L16 3'h0
`define QAMC_MODE_2L14 3'h1
`define QAMC_MODE_2L12 3'h2
`define QAMC_MODE_1L14 3'h5
`define QAMC_FRAME_16 5'h10
`define QAMC_FRAME_14 5'h0e
`define QAMC_FRAME_12 5'h0c
`endif

// ---- verilog/qamc_pkg.sv ----
// Purpose: Types shared by the mode control register bank.
// Assumes: Constants come from qamc_defs.svh.
// Notes: Holds types only.
package qamc_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } qamc_wr_t;
   typedef struct packed {
      logic sleep;
      logic [3:0] nap;
      logic [2:0] driver_current_sel;
      logic internal_term_en;
      logic outputs_disable;
      logic two_lane;
      logic [4:0] frame_bits;
      logic pattern_enable;
      logic [11:0] pattern_data;
      logic pattern_extra_hi;
      logic pattern_extra_lo;
   } qamc_ctrl_t;
endpackage

// ---- verilog/qamc_serial_port.sv ----
// Purpose: Serial shift port on the host's serial clock.
// Assumes: Chip select is active low; data sampled on rising edge.
// Notes: A frame-done level passes the word to the system domain.
`timescale 1ns/100ps
`include "qamc_defs.svh"
module qamc_serial_port
   import qamc_pkg::*;
(
   // Link side
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   output logic sdo_oe_out,
   // Readback byte, held stable by the system domain
   input wire logic [7:0] rd_data_in,
   // Captured word towards the system domain
   output qamc_wr_t word_out,
   output logic word_tgl_out
);
   logic [`QAMC_CNT_W-1:0] cnt, next_cnt;
   logic [15:0] shreg, next_shreg;
   logic [7:0] addr_q, next_addr_q;
   logic sdo_low, next_sdo_low;

   ////////////////////////////////////////////////////////////////////////
   // Chip select high clears the count and output enable; shift and address registers keep their last bits.
   // The flag and address are held from the eighth edge, so the readback
   // source has half a serial period to settle before the data phase needs it.
   always_comb begin
      next_cnt = cnt;
      next_shreg = shreg;
      next_addr_q = addr_q;
      next_sdo_low = 1'b0;
      if (cnt < 5'(`QAMC_WORD_BITS)) begin
         next_shreg = {shreg[14:0], sdi_in};
         next_cnt = cnt + 5'h01;
         if (cnt == 5'(`QAMC_WORD_BITS / 2 - 1)) begin
            next_addr_q = {shreg[6:0], sdi_in};
         end
      end
      // Data bits leave on the falling edge, half a period after the
      // address completes, which gives the system domain time to answer.
      if (addr_q[7] && cnt >= 5'(`QAMC_WORD_BITS / 2) &&
         cnt < 5'(`QAMC_WORD_BITS)) begin
         next_sdo_low = ~rd_data_in[3'(5'h0f - cnt)];
      end
   end

   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         cnt <= 5'h00;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         sdo_low <= 1'b0;
      end else begin
         sdo_low <= next_sdo_low;
      end
   end

   always_ff @(posedge sclk_in) begin
      shreg <= next_shreg;
      addr_q <= next_addr_q;
   end

   assign sdo_oe_out = sdo_low;
   assign word_out = qamc_wr_t'({addr_q, shreg[7:0]});
   // High from the sixteenth edge until chip select rises; a cut frame
   // never raises it.
   assign word_tgl_out = cnt[`QAMC_CNT_W-1];
endmodule

// ---- bench/qamc_regs_monitor.sv ----
// Purpose: Port assertions for the mode control register bank.
// Assumes: Bound to qamc_regs from the bench top.
// Notes: Only the system clock domain is watched.
`timescale 1ns/100ps
module qamc_regs_monitor
   import qamc_pkg::*;
(
   // Watched ports
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic cs_n_in,
   input wire logic sdo_out,
   input wire qamc_ctrl_t ctrl_out,
   input wire logic [3:0] chan_active_out,
   input wire logic cur_code_bad_out,
   input wire logic mode_code_bad_out
);
   logic [3:0] idle;
   logic [3:0] next_idle;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // Flags are registered in the same cycle as ctrl_out, yet they are compared
   // only while ctrl_out is steady and the link has been idle a while.
   always_comb begin
      next_idle = (idle == 4'hf) ? idle : idle + 4'h1;
      if (cs_n_in == 1'b0) begin
         next_idle = 4'h0;
      end
   end
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         idle <= 4'h0;
      end else begin
         idle <= next_idle;
      end
   end
   a_chan_map: assert property (idle > 4'h3 && $stable(ctrl_out)
      ##1 $stable(ctrl_out) |-> $past(chan_active_out) ==
      (ctrl_out.sleep ? 4'h0 : ~ctrl_out.nap))
      else $error("channel enables disagree with nap field");
   a_sleep_all: assert property (ctrl_out.sleep && $past(ctrl_out.sleep)
      && $past(ctrl_out.sleep, 2) |-> $past(chan_active_out) == 4'h0)
      else $error("channel active while asleep");
   a_reset_zero: assert property ($fell(reset_in) |->
      ctrl_out.nap == 4'h0 && !ctrl_out.sleep && !ctrl_out.pattern_enable
      ##[1:3] chan_active_out == 4'hf)
      else $error("state after reset not cleared");
   a_cur_flag: assert property (idle > 4'h3 && $stable(ctrl_out)
      ##1 $stable(ctrl_out) |-> $past(cur_code_bad_out) ==
      (ctrl_out.driver_current_sel == 3'h3))
      else $error("unused current code flag wrong");
   a_mode_flag: assert property (idle > 4'h3 && $stable(ctrl_out)
      ##1 $stable(ctrl_out) |-> !$past(mode_code_bad_out) ||
      (!ctrl_out.two_lane && ctrl_out.frame_bits == 5'h10))
      else $error("reserved mode not single lane");
   a_lane_frame: assert property (idle > 4'h3 |->
      ctrl_out.frame_bits inside {5'h10, 5'h0e} ||
      (ctrl_out.two_lane && ctrl_out.frame_bits == 5'h0c))
      else $error("illegal frame length");
   a_idle_stable: assert property (idle == 4'hf |-> $stable(ctrl_out))
      else $error("control changed without a frame");
   a_sdo_low: assert property (sdo_out == 1'b0)
      else $error("open drain output driven high");
endmodule

// ---- bench/qamc_spi_host.sv ----
// Purpose: Behavioural serial host that writes and reads registers.
// Assumes: 16-bit frames, MSB first, sampled on the rising edge.
// Notes: The serial clock runs only inside a frame.
`timescale 1ns/100ps
module qamc_spi_host
(
   // Serial link
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out,
   input wire logic sdo_in,
   // Readback result
   output logic [7:0] rd_byte_out,
   output logic rd_done_out
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
      rd_byte_out = 8'h00;
      rd_done_out = 1'b0;
   end
   // The odd start offset keeps link edges out of step with clk_sys.
   task automatic xfer(input logic [15:0] w, output logic [7:0] r);
      r = 8'h00;
      #3.7 cs_n_out = 1'b0;
      for (int i = 0; i < 16; i++) begin
         sdi_out = w[15 - i];
         #32;
         // Sampled late so the readback address has had time to settle.
         if (i >= 8) begin
            r = {r[6:0], sdo_in};
         end
         sclk_out = 1'b1;
         #32 sclk_out = 1'b0;
      end
      #32 cs_n_out = 1'b1;
      // A released data line must not keep showing the last bit.
      sdi_out = ~sdi_out;
      if (w[15]) begin
         rd_byte_out = r;
         rd_done_out = 1'b1;
         #1 rd_done_out = 1'b0;
      end
      #400;
   endtask
endmodule

// ---- bench/qamc_regs_test.sv ----
// Purpose: Self-checking bench for the mode control register bank.
// Assumes: Host model drives the serial link at a 64 ns period.
// Notes: Expectations come from a shadow copy of the registers.
`timescale 1ns/100ps
module qamc_regs_test
   import qamc_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic clk_en_in = 1'b1;
   wire logic sclk, cs_n, sdi, sdo, sdo_oe, rd_done;
   wire logic [7:0] rd_byte;
   qamc_ctrl_t ctrl_out;
   qamc_ctrl_t e;
   logic [3:0] chan_active_out;
   logic cur_bad, mode_bad;
   logic [7:0] rg [8];
   logic [7:0] q [$];
   logic [31:0] rs;
   int mismatches = 0;
   int num_checks = 0;
   // The open-drain readback line idles high through its pull-up.
   wire logic sdo_w = sdo_oe ? sdo : 1'b1;
   always #5 clk_sys_in = ~clk_sys_in;
   qamc_regs u_dut(.clk_sys_in, .reset_in, .clk_en_in, .sclk_in(sclk),
      .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
      .ctrl_out, .chan_active_out, .cur_code_bad_out(cur_bad),
      .mode_code_bad_out(mode_bad));
   qamc_spi_host u_host(.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
      .sdo_in(sdo_w), .rd_byte_out(rd_byte), .rd_done_out(rd_done));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic upd;
      e.sleep = rg[1][4];
      e.nap = rg[1][3:0];
      {e.driver_current_sel, e.internal_term_en, e.outputs_disable} =
         rg[2][7:3];
      e.two_lane = rg[2][2:0] < 3'h3;
      e.frame_bits = (rg[2][1:0] == 2'h1) ? 5'h0e :
         (rg[2][2:0] == 3'h2) ? 5'h0c : 5'h10;
      e.pattern_enable = rg[3][7];
      e.pattern_data = {rg[3][5:0], rg[4][7:2]};
      {e.pattern_extra_hi, e.pattern_extra_lo} = rg[4][1:0];
   endtask
   task automatic chk_all;
      check(ctrl_out, e);
      check({chan_active_out, cur_bad, mode_bad}, {(e.sleep ? 4'h0 : ~e.nap),
         rg[2][7:5] == 3'h3, rg[2][2:0] inside {3'h3, 3'h4}});
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_host.xfer({1'b0, a, d}, r);
      if (a == 7'h0 && d[7]) begin
         rg = '{default: 8'h00};
      end else if (a inside {[7'h1:7'h4]}) begin
         rg[a[2:0]] = d;
      end
      upd;
      repeat (8) @(posedge clk_sys_in);
      #1 chk_all;
   endtask
   task automatic rd(input logic [6:0] a);
      logic [7:0] r;
      q.push_back((a inside {[7'h1:7'h4]}) ? rg[a[2:0]] : 8'h00);
      u_host.xfer({1'b1, a, 8'hff}, r);
      chk_all;
   endtask
   task automatic rd_all;
      for (int a = 0; a < 6; a++) begin
         rd(a[6:0]);
      end
   endtask
   always @(posedge rd_done) begin
      check(rd_byte, q.pop_front());
   end
   initial begin
      rs = 32'hf2ca;
      rg = '{default: 8'h00};
      upd;
      repeat (8) @(posedge clk_sys_in);
      #1 reset_in = 1'b0;
      repeat (6) @(posedge clk_sys_in);
      #1 rd_all;
      for (int i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         wr(7'h1, (i == 0) ? 8'h10 : rs[7:0]);
         rd(7'h1);
      end
      for (int m = 0; m < 8; m++) begin
         rs = lfsr(rs);
         wr(7'h2, {m[2:0], rs[1:0], m[2:0]});
         rd(7'h2);
      end
      for (int i = 0; i < 4; i++) begin
         rs = lfsr(rs);
         wr(7'h3, rs[7:0]);
         wr(7'h4, rs[15:8]);
         rd(7'h4);
      end
      wr(7'h55, 8'h5a);
      rd(7'h55);
      wr(7'h0, 8'h80);
      rd_all;
      complete_run;
   end
   initial begin
      #500000;
      mismatches++;
      complete_run;
   end
endmodule
bind qamc_regs qamc_regs_monitor u_mon(.clk_sys_in, .reset_in, .cs_n_in,
   .sdo_out, .ctrl_out, .chan_active_out, .cur_code_bad_out,
   .mode_code_bad_out);
